/* File: verilog/lrp_pkg.sv */
// Constants and carrier types for the light result word packer
package lrp_pkg;

    // ------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------
    localparam int unsigned NUM_CHAN   = 2;
    localparam int unsigned EXP_W      = 4;
    localparam int unsigned VAL_W      = 20;
    localparam int unsigned UPPER_W    = 12;
    localparam int unsigned LOWER_W    = 8;
    localparam int unsigned SEQ_W      = 4;
    localparam int unsigned CHK_W      = 4;
    localparam int unsigned WORD_W     = 16;
    localparam int unsigned BYTE_W     = 8;
    localparam int unsigned PTR_W      = 8;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] CH0_RANGE_AND_UPPER_BITS   = 8'h00;
    localparam logic [7:0] CH0_LOWER_BITS_COUNT_CHECK = 8'h01;
    localparam logic [7:0] CH1_RANGE_AND_UPPER_BITS   = 8'h02;
    localparam logic [7:0] CH1_LOWER_BITS_COUNT_CHECK = 8'h03;
    localparam logic [7:0] QUEUED_CH0_UPPER_WORD      = 8'h04;
    localparam logic [7:0] QUEUED_CH0_LOWER_WORD      = 8'h05;
    localparam logic [7:0] QUEUED_CH1_UPPER_WORD      = 8'h06;
    localparam logic [7:0] QUEUED_CH1_LOWER_WORD      = 8'h07;
    localparam logic [7:0] LOW_LIMIT                  = 8'h08;
    localparam logic [7:0] HIGH_LIMIT                 = 8'h09;
    localparam logic [7:0] MAIN_CONFIGURATION         = 8'h0A;
    localparam logic [7:0] ALERT_AND_BUS_CONFIGURATION = 8'h0B;
    localparam logic [7:0] CONDITION_FLAGS            = 8'h0C;
    localparam logic [7:0] PART_IDENTIFICATION        = 8'h11;

    // ------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------
    localparam int unsigned EXP_LSB    = 12;
    localparam int unsigned LOWER_LSB  = 8;
    localparam int unsigned SEQ_LSB    = 4;
    localparam int unsigned CHK_LSB    = 0;
    localparam logic [SEQ_W-1:0]  SEQ_STEP   = 4'h1;
    localparam logic [WORD_W-1:0] WORD_RESET = 16'h0000;
    localparam logic [PTR_W-1:0]  PTR_RESET  = 8'h00;
    localparam logic [PTR_W-1:0]  PTR_STEP   = 8'h01;
    localparam logic [BYTE_W-1:0] BYTE_ZERO  = 8'h00;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic [EXP_W-1:0] range_exp;
        logic [VAL_W-1:0] scaled_light_value;
    } lrp_sample_s;

    typedef struct packed {
        logic [EXP_W-1:0] range_exp;
        logic [VAL_W-1:0] scaled_light_value;
        logic [SEQ_W-1:0] sample_seq;
        logic [CHK_W-1:0] check_code;
    } lrp_chan_s;

    typedef struct packed {
        logic             set_ptr;
        logic [PTR_W-1:0] ptr_value;
        logic             byte_rd;
        logic             stop;
    } lrp_port_req_s;

    typedef enum logic [0:0] {
        LRP_HIGH_BYTE = 1'b0,
        LRP_LOW_BYTE  = 1'b1
    } lrp_phase_e;

endpackage

/* File: verilog/lrp_check_calc.sv */
// Four-bit check code over one channel's exponent, value and sample count
`timescale 1ns/10ps
`default_nettype none
module lrp_check_calc (
    // Sample fields
    input  wire logic [lrp_pkg::EXP_W-1:0] i_range_exp,
    input  wire logic [lrp_pkg::VAL_W-1:0] i_scaled_light_value,
    input  wire logic [lrp_pkg::SEQ_W-1:0] i_sample_seq,
    // Check code, bit n at position n
    output logic      [lrp_pkg::CHK_W-1:0] o_check_code
);
    import lrp_pkg::*;

    logic [VAL_W-1:0] r;
    logic [EXP_W-1:0] e;
    logic [SEQ_W-1:0] c;

    assign r = i_scaled_light_value;
    assign e = i_range_exp;
    assign c = i_sample_seq;

    always_comb begin
        o_check_code[0] = (^e) ^ (^r) ^ (^c);
        o_check_code[1] = c[1] ^ c[3] ^ r[1] ^ r[3] ^ r[5] ^ r[7] ^ r[9] ^ r[11]
                        ^ r[13] ^ r[15] ^ r[17] ^ r[19] ^ e[1] ^ e[3];
        o_check_code[2] = c[3] ^ r[3] ^ r[7] ^ r[11] ^ r[15] ^ r[19] ^ e[3];
        o_check_code[3] = r[3] ^ r[11] ^ r[19];
    end

endmodule
`default_nettype wire

/* File: verilog/lrp_result_bank.sv */
// Result register bank: per-channel words, check codes and byte read-out
`timescale 1ns/10ps
`default_nettype none
module lrp_result_bank (
    // Clock and reset
    input  wire logic                           i_core_clk,
    input  wire logic                           i_rst_b,
    input  wire logic                           i_gc_reset,
    // Conversion sequencer
    input  wire logic [lrp_pkg::NUM_CHAN-1:0]   i_conv_done,
    input  wire lrp_pkg::lrp_sample_s           i_conv_sample [lrp_pkg::NUM_CHAN],
    // Serial engine side
    input  wire lrp_pkg::lrp_port_req_s         i_port_req,
    input  wire logic                           i_burst_en,
    output logic                                o_rd_valid,
    output logic      [lrp_pkg::BYTE_W-1:0]     o_rd_byte,
    output logic      [lrp_pkg::PTR_W-1:0]      o_rd_ptr,
    output logic                                o_rd_mapped,
    // Stored channel state
    output lrp_pkg::lrp_chan_s                  o_chan [lrp_pkg::NUM_CHAN],
    output logic      [lrp_pkg::NUM_CHAN-1:0]   o_chan_updated
);
    import lrp_pkg::*;

    // ------------------------------------------------------------
    // Local signals
    // ------------------------------------------------------------
    logic                 clear_all;
    lrp_chan_s            chan_r       [NUM_CHAN];
    lrp_chan_s            chan_nxt     [NUM_CHAN];
    logic [CHK_W-1:0]     chk_nxt      [NUM_CHAN];
    logic [NUM_CHAN-1:0]  updated_r;
    logic [WORD_W-1:0]    upper_word   [NUM_CHAN];
    logic [WORD_W-1:0]    lower_word   [NUM_CHAN];

    logic [PTR_W-1:0]     base_ptr_r;
    logic [PTR_W-1:0]     ptr_r;
    logic [PTR_W-1:0]     ptr_nxt;
    lrp_phase_e           phase_r;
    lrp_phase_e           phase_nxt;
    logic [WORD_W-1:0]    sel_word;
    logic                 sel_mapped;
    logic                 rd_valid_r;
    logic [BYTE_W-1:0]    rd_byte_r;
    logic                 mapped_r;

    // General-call reset acts like power-on reset on this bank
    assign clear_all = !i_rst_b || i_gc_reset;

    // ------------------------------------------------------------
    // Per-channel capture
    // ------------------------------------------------------------
    genvar ch;
    generate
        for (ch = 0; ch < NUM_CHAN; ch++) begin : g_chan
            // New count first, so the check covers the value it is stored with
            always_comb begin
                chan_nxt[ch].range_exp          = i_conv_sample[ch].range_exp;
                chan_nxt[ch].scaled_light_value = i_conv_sample[ch].scaled_light_value;
                chan_nxt[ch].sample_seq         = chan_r[ch].sample_seq + SEQ_STEP;
                chan_nxt[ch].check_code         = chk_nxt[ch];
            end

            lrp_check_calc u_check (
                .i_range_exp          (i_conv_sample[ch].range_exp),
                .i_scaled_light_value (i_conv_sample[ch].scaled_light_value),
                .i_sample_seq         (chan_nxt[ch].sample_seq),
                .o_check_code         (chk_nxt[ch])
            );

            // All four fields load in one edge, so one byte read never straddles two samples; the two bytes of a word are not held together
            always_ff @(posedge i_core_clk) begin
                if (clear_all) begin
                    chan_r[ch] <= '0;
                end else if (i_conv_done[ch]) begin
                    chan_r[ch] <= chan_nxt[ch];
                end
            end

            always_ff @(posedge i_core_clk) begin
                if (clear_all) begin
                    updated_r[ch] <= 1'b0;
                end else begin
                    updated_r[ch] <= i_conv_done[ch];
                end
            end

            // Word layout is shared by both channels
            always_comb begin
                upper_word[ch] = {chan_r[ch].range_exp,
                                  chan_r[ch].scaled_light_value[VAL_W-1 -: UPPER_W]};
                lower_word[ch] = {chan_r[ch].scaled_light_value[LOWER_W-1:0],
                                  chan_r[ch].sample_seq,
                                  chan_r[ch].check_code};
            end

            assign o_chan[ch] = chan_r[ch];
        end
    endgenerate

    assign o_chan_updated = updated_r;

    // ------------------------------------------------------------
    // Word select
    // ------------------------------------------------------------
    // Only the live result words are held here; other offsets read zero
    always_comb begin
        sel_word   = WORD_RESET;
        sel_mapped = 1'b1;
        unique case (ptr_r)
            CH0_RANGE_AND_UPPER_BITS:   sel_word = upper_word[0];
            CH0_LOWER_BITS_COUNT_CHECK: sel_word = lower_word[0];
            CH1_RANGE_AND_UPPER_BITS:   sel_word = upper_word[1];
            CH1_LOWER_BITS_COUNT_CHECK: sel_word = lower_word[1];
            default: begin
                sel_word   = WORD_RESET;
                sel_mapped = 1'b0;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Pointer and byte phase
    // ------------------------------------------------------------
    always_comb begin
        ptr_nxt   = ptr_r;
        phase_nxt = phase_r;
        if (i_port_req.set_ptr) begin
            ptr_nxt   = i_port_req.ptr_value;
            phase_nxt = LRP_HIGH_BYTE;
        end else if (i_port_req.stop) begin
            ptr_nxt   = base_ptr_r;
            phase_nxt = LRP_HIGH_BYTE;
        end else if (i_port_req.byte_rd) begin
            unique case (phase_r)
                LRP_HIGH_BYTE: begin
                    phase_nxt = LRP_LOW_BYTE;
                end
                LRP_LOW_BYTE: begin
                    phase_nxt = LRP_HIGH_BYTE;
                    if (i_burst_en) begin
                        ptr_nxt = ptr_r + PTR_STEP;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (clear_all) begin
            ptr_r   <= PTR_RESET;
            phase_r <= LRP_HIGH_BYTE;
        end else begin
            ptr_r   <= ptr_nxt;
            phase_r <= phase_nxt;
        end
    end

    // Start value that a stop brings the pointer back to
    always_ff @(posedge i_core_clk) begin
        if (clear_all) begin
            base_ptr_r <= PTR_RESET;
        end else if (i_port_req.set_ptr) begin
            base_ptr_r <= i_port_req.ptr_value;
        end
    end

    // ------------------------------------------------------------
    // Byte read-out
    // ------------------------------------------------------------
    // A read arriving with set_ptr or stop is dropped; engine never overlaps them
    always_ff @(posedge i_core_clk) begin
        if (clear_all) begin
            rd_valid_r <= 1'b0;
        end else begin
            rd_valid_r <= i_port_req.byte_rd && !i_port_req.set_ptr && !i_port_req.stop;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (clear_all) begin
            rd_byte_r <= BYTE_ZERO;
            mapped_r  <= 1'b0;
        end else if (i_port_req.byte_rd && !i_port_req.set_ptr && !i_port_req.stop) begin
            mapped_r <= sel_mapped;
            if (phase_r == LRP_HIGH_BYTE) begin
                rd_byte_r <= sel_word[WORD_W-1 -: BYTE_W];
            end else begin
                rd_byte_r <= sel_word[BYTE_W-1:0];
            end
        end
    end

    assign o_rd_valid  = rd_valid_r;
    assign o_rd_byte   = rd_byte_r;
    assign o_rd_mapped = mapped_r;
    assign o_rd_ptr    = ptr_r;

endmodule
`default_nettype wire

/* File: tb/lrp_result_bank_checker.sv */
// Port assertions for the result register bank
`timescale 1ns/10ps
`default_nettype none
module lrp_result_bank_checker (
    // Clock, reset and inputs
    input wire logic                         i_core_clk,
    input wire logic                         i_rst_b,
    input wire logic                         i_gc_reset,
    input wire logic [lrp_pkg::NUM_CHAN-1:0] i_conv_done,
    input wire lrp_pkg::lrp_sample_s         i_conv_sample [lrp_pkg::NUM_CHAN],
    input wire lrp_pkg::lrp_port_req_s       i_port_req,
    // Outputs
    input wire logic                         o_rd_valid,
    input wire logic [lrp_pkg::BYTE_W-1:0]   o_rd_byte,
    input wire logic                         o_rd_mapped,
    input wire lrp_pkg::lrp_chan_s           o_chan [lrp_pkg::NUM_CHAN],
    input wire logic [lrp_pkg::NUM_CHAN-1:0] o_chan_updated
);
    import lrp_pkg::*;
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_b || i_gc_reset);
    lrp_chan_s c0;
    lrp_chan_s c1;
    logic      rd_take;
    assign c0 = o_chan[0];
    assign c1 = o_chan[1];
    assign rd_take = i_port_req.byte_rd && !i_port_req.set_ptr && !i_port_req.stop;
    // Reset sampled at the start edge clears the bank, so that edge makes no claim
    sequence s_cap0;
        i_conv_done[0] && i_rst_b && !i_gc_reset;
    endsequence
    sequence s_cap1;
        i_conv_done[1] && i_rst_b && !i_gc_reset;
    endsequence
    AST_CAPTURE: assert property (s_cap0 |=> {c0.range_exp, c0.scaled_light_value}
        == $past(i_conv_sample[0])) else $error("capture mismatch");
    AST_SEQ_STEP: assert property (s_cap1 |=>
        c1.sample_seq == $past(c1.sample_seq) + 4'h1) else $error("count step wrong");
    AST_HOLD: assert property (!i_conv_done[0] && i_rst_b && !i_gc_reset
        |=> $stable(c0)) else $error("fields changed without capture");
    AST_UPDATED: assert property (s_cap0 |=> o_chan_updated[0])
        else $error("update pulse missing");
    AST_CHK0: assert property (c0.check_code[0] == ^{c0.range_exp,
        c0.scaled_light_value, c0.sample_seq}) else $error("check bit 0 wrong");
    AST_CHK1: assert property (c1.check_code[1] == ^{c1.sample_seq[1],
        c1.sample_seq[3], c1.scaled_light_value & 20'ha_aaaa, c1.range_exp[1],
        c1.range_exp[3]}) else $error("check bit 1 wrong");
    AST_CHK2: assert property (c0.check_code[2] == ^{c0.sample_seq[3],
        c0.range_exp[3], c0.scaled_light_value & 20'h8_8888}) else $error("check bit 2 wrong");
    AST_CHK3: assert property (c1.check_code[3] ==
        ^(c1.scaled_light_value & 20'h8_0808)) else $error("check bit 3 wrong");
    AST_RD_VALID: assert property (i_rst_b && !i_gc_reset |=>
        o_rd_valid == $past(rd_take)) else $error("read valid timing wrong");
    AST_UNMAPPED: assert property (o_rd_valid && !o_rd_mapped |->
        o_rd_byte == BYTE_ZERO) else $error("unmapped byte not zero");
endmodule
bind lrp_result_bank lrp_result_bank_checker lrp_result_bank_checker_i (
    .i_core_clk(i_core_clk), .i_rst_b(i_rst_b), .i_gc_reset(i_gc_reset),
    .i_conv_done(i_conv_done), .i_conv_sample(i_conv_sample), .i_port_req(i_port_req),
    .o_rd_valid(o_rd_valid), .o_rd_byte(o_rd_byte), .o_rd_mapped(o_rd_mapped),
    .o_chan(o_chan), .o_chan_updated(o_chan_updated)
);
`default_nettype wire

/* File: tb/lrp_host_model.sv */
// Host model: pointer set, byte reads, stop and check recompute
`timescale 1ns/10ps
`default_nettype none
module lrp_host_model (
    // Clock
    input  wire logic                       i_core_clk,
    // Requests to the bank
    output lrp_pkg::lrp_port_req_s          o_port_req,
    output logic                            o_burst_en,
    // Read answers
    input  wire logic                       i_rd_valid,
    input  wire logic [lrp_pkg::BYTE_W-1:0] i_rd_byte
);
    import lrp_pkg::*;
    initial begin
        o_port_req = '0;
        o_burst_en = 1'b0;
    end
    task automatic set_ptr(input logic [PTR_W-1:0] p, input logic burst);
        @(posedge i_core_clk);
        o_port_req.set_ptr <= 1'b1;
        o_port_req.ptr_value <= p;
        o_burst_en <= burst;
        @(posedge i_core_clk);
        o_port_req.set_ptr <= 1'b0;
    endtask
    task automatic read_byte(output logic [BYTE_W-1:0] b, output bit ok);
        @(posedge i_core_clk);
        o_port_req.byte_rd <= 1'b1;
        @(posedge i_core_clk);
        o_port_req.byte_rd <= 1'b0;
        ok = 1'b0;
        for (int k = 0; k < 8 && !ok; k++) begin
            #1;
            ok = (i_rd_valid === 1'b1);
            b = i_rd_byte;
            if (!ok) @(posedge i_core_clk);
        end
    endtask
    task automatic read_word(output logic [WORD_W-1:0] w, output bit ok);
        bit ok_lo;
        read_byte(w[15:8], ok);
        read_byte(w[7:0], ok_lo);
        ok = ok && ok_lo;
    endtask
    task automatic send_stop();
        @(posedge i_core_clk);
        o_port_req.stop <= 1'b1;
        @(posedge i_core_clk);
        o_port_req.stop <= 1'b0;
        #1;
    endtask
    // Host-side recompute, used to build the expected check code of each sample
    function automatic logic [CHK_W-1:0] calc_check(lrp_chan_s c);
        logic [VAL_W-1:0] v;
        v = c.scaled_light_value;
        calc_check[0] = ^{c.range_exp, v, c.sample_seq};
        calc_check[1] = ^{c.sample_seq[1], c.sample_seq[3], v & 20'ha_aaaa,
            c.range_exp[1], c.range_exp[3]};
        calc_check[2] = ^{c.sample_seq[3], v & 20'h8_8888, c.range_exp[3]};
        calc_check[3] = v[3] ^ v[11] ^ v[19];
    endfunction
endmodule
`default_nettype wire

/* File: tb/tb_light_result_word_packer.sv */
// Self-checking testbench for the result register bank
`timescale 1ns/10ps
`default_nettype none
`define CHECK(a, b) begin num_checks++; if ((a) !== (b)) begin mismatches++; \
    $display("Error %0t: got %h expected %h", $time, a, b); end end
module tb_light_result_word_packer;
    import lrp_pkg::*;
    logic                i_core_clk = 1'b0;
    logic                i_rst_b = 1'b0;
    logic                i_gc_reset = 1'b0;
    logic [NUM_CHAN-1:0] i_conv_done = '0;
    lrp_sample_s         i_conv_sample [NUM_CHAN];
    lrp_port_req_s       port_req;
    logic                burst_en;
    logic                rd_valid;
    logic                rd_mapped;
    logic [BYTE_W-1:0]   rd_byte;
    logic [PTR_W-1:0]    rd_ptr;
    lrp_chan_s           chan [NUM_CHAN];
    lrp_chan_s           exp_c [NUM_CHAN];
    logic [31:0]         lfsr_r = 32'hcd3c;
    int                  mismatches = 0;
    int                  num_checks = 0;
    always #5 i_core_clk = ~i_core_clk;
    lrp_result_bank lrp_result_bank_i (
        .i_core_clk(i_core_clk), .i_rst_b(i_rst_b), .i_gc_reset(i_gc_reset),
        .i_conv_done(i_conv_done), .i_conv_sample(i_conv_sample), .i_port_req(port_req),
        .i_burst_en(burst_en), .o_rd_valid(rd_valid), .o_rd_byte(rd_byte),
        .o_rd_ptr(rd_ptr), .o_rd_mapped(rd_mapped), .o_chan(chan), .o_chan_updated()
    );
    lrp_host_model lrp_host_model_i (
        .i_core_clk(i_core_clk), .o_port_req(port_req), .o_burst_en(burst_en),
        .i_rd_valid(rd_valid), .i_rd_byte(rd_byte)
    );
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] lfsr_next(logic [31:0] s);
        return s[0] ? ((s >> 1) ^ 32'h8020_0003) : (s >> 1);
    endfunction
    function automatic logic [WORD_W-1:0] exp_word(lrp_chan_s c, bit lo);
        return lo ? {c.scaled_light_value[7:0], c.sample_seq, c.check_code}
                  : {c.range_exp, c.scaled_light_value[19:8]};
    endfunction
    task automatic finish_test();
        $display("Checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic read_check(input logic [WORD_W-1:0] w);
        logic [WORD_W-1:0] got;
        bit                ok;
        lrp_host_model_i.read_word(got, ok);
        if (!ok) begin
            mismatches++;
            $display("Error %0t: read timeout", $time);
            finish_test();
        end else `CHECK(got, w)
    endtask
    // Same sample into every masked channel in one cycle
    task automatic convert(input logic [NUM_CHAN-1:0] m, input lrp_sample_s s);
        @(posedge i_core_clk);
        i_conv_done <= m;
        for (int c = 0; c < NUM_CHAN; c++) i_conv_sample[c] <= s;
        @(posedge i_core_clk);
        i_conv_done <= '0;
        #1;
        for (int c = 0; c < NUM_CHAN; c++) if (m[c]) begin
            exp_c[c] = {s, exp_c[c].sample_seq + SEQ_STEP, 4'h0};
            exp_c[c].check_code = lrp_host_model_i.calc_check(exp_c[c]);
            `CHECK(chan[c], exp_c[c])
        end
    endtask
    task automatic read_all();
        lrp_host_model_i.set_ptr(PTR_RESET, 1'b1);
        for (int w = 0; w < 4; w++) read_check(exp_word(exp_c[w / 2], w[0]));
        `CHECK(rd_ptr, 8'h04)
        lrp_host_model_i.send_stop();
        `CHECK(rd_ptr, PTR_RESET)
    endtask
    initial begin
        repeat (100000) @(posedge i_core_clk);
        mismatches++;
        $display("Error %0t: run timed out", $time);
        finish_test();
    end
    initial begin
        for (int c = 0; c < NUM_CHAN; c++) begin
            i_conv_sample[c] = '0;
            exp_c[c] = '0;
        end
        repeat (5) @(posedge i_core_clk);
        i_rst_b <= 1'b1;
        read_all();
        $display("Test reset values done");
        for (int i = 0; i < 36; i++) begin
            lfsr_r = lfsr_next(lfsr_r);
            if (i < 2) convert(2'b11, i == 0 ? 24'hff_ffff : 24'h00_0008);
            else convert(2'((i % 3) + 1), lfsr_r[23:0]);
            read_all();
        end
        $display("Test random conversions done");
        lrp_host_model_i.set_ptr(8'h03, 1'b0);
        read_check(exp_word(exp_c[1], 1'b1));
        read_check(exp_word(exp_c[1], 1'b1));
        `CHECK(rd_ptr, 8'h03)
        `CHECK(rd_mapped, 1'b1)
        lrp_host_model_i.set_ptr(8'h01, 1'b1);
        read_check(exp_word(exp_c[0], 1'b1));
        read_check(exp_word(exp_c[1], 1'b0));
        `CHECK(rd_ptr, 8'h03)
        lrp_host_model_i.send_stop();
        `CHECK(rd_ptr, 8'h01)
        lrp_host_model_i.set_ptr(LOW_LIMIT, 1'b0);
        read_check(WORD_RESET);
        `CHECK(rd_mapped, 1'b0)
        $display("Test repeat and unmapped reads done");
        @(posedge i_core_clk);
        i_gc_reset <= 1'b1;
        @(posedge i_core_clk);
        i_gc_reset <= 1'b0;
        #1;
        for (int c = 0; c < NUM_CHAN; c++) exp_c[c] = '0;
        `CHECK(chan[0], exp_c[0])
        convert(2'b11, 24'h5a_5a5a);
        read_all();
        $display("Test general-call reset done");
        finish_test();
    end
endmodule
`default_nettype wire
